// *** design/ioxp_pkg.sv ***
// package for the i2c quasi-bidirectional io expander
package ioxp_pkg;
	// ==========================================
	// address decode
	localparam logic [3:0] ADDR_PFX_BASE = 4'h4; // base variant prefix
	localparam logic [3:0] ADDR_PFX_ALT = 4'h7; // alternate variant prefix
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00; // reserved general call
	localparam logic [6:0] DEV_ID_ADDR = 7'h7C; // reserved device id address
	// ==========================================
	// port and byte framing
	localparam int DATA_W = 8; // port width
	localparam int FIFO_DEPTH = 32; // queued written bytes
	localparam logic [7:0] PORT_RESET = 8'hFF; // all pins weakly high
	localparam logic [3:0] ACK_SLOT = 4'h8; // ninth clock of a byte
	localparam logic [3:0] HOLD_SLOT = 4'h4; // snapshot freeze point
	localparam logic [1:0] CLR_CYCLES = 2'h3; // interrupt re-arm window
	localparam logic [1:0] ID_LAST = 2'h2; // index of last id byte
	// ==========================================
	// identification bytes, values are arbitrary
	localparam logic [7:0] ID_MAKER = 8'h5A; // arbitrary
	localparam logic [7:0] ID_PART = 8'h08; // arbitrary
	localparam logic [7:0] ID_REV = 8'h01; // arbitrary
	// ==========================================
	// link state machine
	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_ADDR = 2'b01,
		LK_WDATA = 2'b10,
		LK_RDATA = 2'b11
	} ioxp_lk_state_t;
	// written byte with its event toggle
	typedef struct packed {
		logic [7:0] data;
		logic tog;
	} ioxp_wr_t;
endpackage

// *** design/ioxp_top.sv ***
// i2c io expander: scl-domain slave, byte queue and port logic
// Contract
// - reset leaves all port pins weakly high
// - three straps give low address bits
// - prefix 0100 base, 0111 alternate variant
// - alternate variant refuses reserved addresses except device id reads
// - address lsb one reads, zero writes
// - open-drain active-low interrupt output
// - written port value held in latch
// - identification bytes readable over bus
// - acknowledged write byte drives port pins
// - read bytes carry current pin levels
// - any input edge outside the re-arm window raises interrupt
// - interrupt drops on restore or access
`timescale 1ns/1ns

// ==========================================
// byte queue between link and port latch
module ioxp_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D]; // storage
	logic [AW:0] wp_reg; // write pointer, extra wrap bit
	logic [AW:0] rp_reg; // read pointer
	wire full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
	wire empty = wp_reg == rp_reg;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rp_reg[AW-1:0]];
	// storage write, no reset needed
	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem[wp_reg[AW-1:0]] <= in_data_i;
		end
	end
	// pointers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			if (in_valid_i && !full) begin
				wp_reg <= wp_reg + 1'b1;
			end
			if (out_ready_i && !empty) begin
				rp_reg <= rp_reg + 1'b1;
			end
		end
	end
	// refused push must leave the write pointer alone
	full_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!in_ready_o |=> $stable(wp_reg)) else $error("fifo took data while full");
endmodule

// ==========================================
// top level
module ioxp_top #(
	parameter bit ALT_VARIANT = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic addr_strap_bit0_i,
	input wire logic addr_strap_bit1_i,
	input wire logic addr_strap_bit2_i,
	input wire logic [7:0] port_pin_i,
	output logic [7:0] port_pin_o,
	output logic [7:0] port_pin_oe_n_o,
	input wire logic port_freeze_i,
	output logic irq_o,
	output logic irq_oe_n_o
);
	// ==========================================
	// link domain (scl) declarations
	ioxp_pkg::ioxp_lk_state_t st_reg; // byte framing state
	logic [3:0] cnt_reg; // clock count within byte
	logic [7:0] sr_reg; // receive shifter
	logic [7:0] tx_reg; // byte being sent
	logic start_pend; // start seen, not yet consumed
	logic start_seen; // clears start_pend
	logic id_mode_reg; // reading the id bytes
	logic [1:0] id_idx_reg; // which id byte
	logic hold_reg; // freeze request to sys side
	logic rd_tog_reg; // read access event
	ioxp_pkg::ioxp_wr_t wr_reg; // written byte and its toggle
	logic bp_l1, bp_l2; // back-pressure sync
	logic sda_oe_n_reg; // data line drive, low = pull low
	// ==========================================
	// system domain declarations
	logic [7:0] pin_s1, pin_s2; // pin sync
	logic [2:0] strap_s1, strap_s2; // strap sync
	logic [2:0] strap_reg; // captured strap levels
	logic strap_done; // strap capture taken
	logic [1:0] strap_wait_reg; // sync fill delay before capture
	logic hold_s1, hold_s2; // freeze sync
	logic [7:0] snap_reg; // pin snapshot for reads
	logic wt_s1, wt_s2, wt_s3; // write toggle sync
	logic rt_s1, rt_s2, rt_s3; // read toggle sync
	logic frz_s1, frz_s2; // freeze input sync
	logic pend_v; // skid stage valid
	logic [7:0] pend_d; // skid stage data
	logic bp_reg; // queue cannot take more
	logic [7:0] latch_reg; // port output latch
	logic [7:0] ref_reg; // reference pin setting
	logic [1:0] clr_reg; // re-arm countdown
	logic irq_reg; // interrupt active
	logic q_ready, q_valid; // queue handshakes
	logic [7:0] q_data; // queue head
	wire wr_evt = wt_s2 ^ wt_s3;
	wire rd_evt = rt_s2 ^ rt_s3;
	wire pop = q_valid && !frz_s2;

	// ==========================================
	// address decode
	// own address from prefix and straps
	wire [6:0] my_addr = {ALT_VARIANT ? ioxp_pkg::ADDR_PFX_ALT : ioxp_pkg::ADDR_PFX_BASE,
		strap_reg};
	// reserved addresses never taken as own
	wire rsv = ALT_VARIANT && (sr_reg[7:1] == ioxp_pkg::GEN_CALL_ADDR ||
		sr_reg[7:1] == ioxp_pkg::DEV_ID_ADDR);
	wire id_hit = sr_reg[7:1] == ioxp_pkg::DEV_ID_ADDR && sr_reg[0];
	wire own_hit = sr_reg[7:1] == my_addr && !rsv;
	wire addr_hit = own_hit || id_hit;
	wire ack_slot = cnt_reg == ioxp_pkg::ACK_SLOT;
	wire ack_now = ack_slot && ((st_reg == ioxp_pkg::LK_ADDR && addr_hit) ||
		(st_reg == ioxp_pkg::LK_WDATA && !bp_l2));

	// ==========================================
	// start detector, sda acts as its clock
	wire start_rst = sys_rst_i | start_seen;
	always_ff @(negedge sda_i or posedge start_rst) begin
		if (start_rst) begin
			start_pend <= 1'b0;
		end else if (scl_i) begin
			start_pend <= 1'b1;
		end
	end
	// consume the start on first clock
	always_ff @(posedge scl_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			start_seen <= 1'b0;
		end else begin
			start_seen <= start_pend;
		end
	end
	// back-pressure level into link domain
	always_ff @(posedge scl_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bp_l1 <= 1'b1;
			bp_l2 <= 1'b1;
		end else begin
			bp_l1 <= bp_reg;
			bp_l2 <= bp_l1;
		end
	end

	// ==========================================
	// byte framing, sampled on rising scl
	always_ff @(posedge scl_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= ioxp_pkg::LK_IDLE;
			cnt_reg <= 4'h0;
			sr_reg <= 8'h00;
		end else if (start_pend) begin
			// first byte after start is address
			st_reg <= ioxp_pkg::LK_ADDR;
			cnt_reg <= 4'h1;
			sr_reg <= {7'h00, sda_i};
		end else if (st_reg == ioxp_pkg::LK_IDLE) begin
			cnt_reg <= 4'h0;
		end else if (!ack_slot) begin
			sr_reg <= {sr_reg[6:0], sda_i};
			cnt_reg <= cnt_reg + 4'h1;
		end else begin
			cnt_reg <= 4'h0;
			unique case (st_reg)
				ioxp_pkg::LK_IDLE: st_reg <= ioxp_pkg::LK_IDLE;
				ioxp_pkg::LK_ADDR: st_reg <= !addr_hit ? ioxp_pkg::LK_IDLE :
					sr_reg[0] ? ioxp_pkg::LK_RDATA : ioxp_pkg::LK_WDATA;
				// refused byte ends the write
				ioxp_pkg::LK_WDATA: st_reg <= sda_oe_n_reg ? ioxp_pkg::LK_IDLE : st_reg;
				// master nack ends the read
				ioxp_pkg::LK_RDATA: st_reg <= sda_i ? ioxp_pkg::LK_IDLE : st_reg;
			endcase
		end
	end
	// written byte handed over on its ack clock
	always_ff @(posedge scl_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_reg <= '0;
		end else if (!start_pend && ack_slot && st_reg == ioxp_pkg::LK_WDATA &&
			!sda_oe_n_reg) begin
			// only acknowledged bytes go to port
			wr_reg.data <= sr_reg;
			wr_reg.tog <= !wr_reg.tog;
		end
	end
	// read byte load and snapshot freeze request
	wire load_rd = !start_pend && ack_slot && ((st_reg == ioxp_pkg::LK_ADDR &&
		addr_hit && sr_reg[0]) || (st_reg == ioxp_pkg::LK_RDATA && !sda_i));
	wire id_load = st_reg == ioxp_pkg::LK_ADDR ? !own_hit : id_mode_reg;
	always_ff @(posedge scl_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_reg <= 8'hFF;
			hold_reg <= 1'b0;
			id_mode_reg <= 1'b0;
			id_idx_reg <= 2'h0;
			rd_tog_reg <= 1'b0;
		end else if (load_rd) begin
			hold_reg <= 1'b0;
			id_mode_reg <= id_load;
			if (id_load) begin
				// id bytes in turn, then repeat
				unique case (id_idx_reg)
					2'h0: tx_reg <= ioxp_pkg::ID_MAKER;
					2'h1: tx_reg <= ioxp_pkg::ID_PART;
					default: tx_reg <= ioxp_pkg::ID_REV;
				endcase
				id_idx_reg <= id_idx_reg == ioxp_pkg::ID_LAST ? 2'h0 : id_idx_reg + 2'h1;
			end else begin
				tx_reg <= snap_reg;
				rd_tog_reg <= !rd_tog_reg;
			end
		end else begin
			if (st_reg == ioxp_pkg::LK_ADDR && cnt_reg == ioxp_pkg::HOLD_SLOT) begin
				id_idx_reg <= 2'h0;
			end
			// freeze well before the ack clock
			if (cnt_reg == ioxp_pkg::HOLD_SLOT && st_reg != ioxp_pkg::LK_WDATA) begin
				hold_reg <= 1'b1;
			end else if (st_reg == ioxp_pkg::LK_IDLE || st_reg == ioxp_pkg::LK_WDATA) begin
				// outside reads the snapshot must follow the pins again
				hold_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// data line drive, changed on falling scl
	always_ff @(negedge scl_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sda_oe_n_reg <= 1'b1;
		end else if (start_pend) begin
			sda_oe_n_reg <= 1'b1;
		end else if (ack_now) begin
			sda_oe_n_reg <= 1'b0;
		end else if (st_reg == ioxp_pkg::LK_RDATA && !ack_slot) begin
			sda_oe_n_reg <= tx_reg[3'h7 - cnt_reg[2:0]];
		end else begin
			sda_oe_n_reg <= 1'b1;
		end
	end
	assign sda_o = 1'b0;
	assign sda_oe_n_o = sda_oe_n_reg;

	// link checks on rising scl
	sequence addr_done_s;
		st_reg == ioxp_pkg::LK_ADDR && ack_slot && !start_pend;
	endsequence
	addr_ack_a: assert property (@(posedge scl_i) disable iff (sys_rst_i)
		addr_done_s ##0 (sr_reg[7:1] == my_addr && !rsv) |-> !sda_oe_n_reg)
		else $error("own address not acknowledged");
	addr_nack_a: assert property (@(posedge scl_i) disable iff (sys_rst_i)
		addr_done_s ##0 !addr_hit |-> sda_oe_n_reg ##1 st_reg == ioxp_pkg::LK_IDLE)
		else $error("foreign address acknowledged");
	rsv_refuse_a: assert property (@(posedge scl_i) disable iff (sys_rst_i)
		addr_done_s ##0 rsv ##0 !id_hit |-> sda_oe_n_reg)
		else $error("reserved address acknowledged");
	dir_select_a: assert property (@(posedge scl_i) disable iff (sys_rst_i)
		addr_done_s ##0 own_hit |=> st_reg == (sr_reg[0] ? ioxp_pkg::LK_RDATA :
		ioxp_pkg::LK_WDATA)) else $error("wrong direction");
	read_snap_a: assert property (@(posedge scl_i) disable iff (sys_rst_i)
		load_rd && !id_load |=> tx_reg == $past(snap_reg))
		else $error("read byte not pin snapshot");
	write_hand_a: assert property (@(posedge scl_i) disable iff (sys_rst_i)
		st_reg == ioxp_pkg::LK_WDATA && ack_slot && !start_pend && !sda_oe_n_reg |=>
		wr_reg.data == $past(sr_reg) && $changed(wr_reg.tog))
		else $error("acked byte not handed over");

	// ==========================================
	// system side synchronisers
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_s1 <= 8'hFF;
			pin_s2 <= 8'hFF;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
			hold_s1 <= 1'b0;
			hold_s2 <= 1'b0;
			{wt_s1, wt_s2, wt_s3} <= 3'h0;
			{rt_s1, rt_s2, rt_s3} <= 3'h0;
			frz_s1 <= 1'b0;
			frz_s2 <= 1'b0;
		end else begin
			pin_s1 <= port_pin_i;
			pin_s2 <= pin_s1;
			strap_s1 <= {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i};
			strap_s2 <= strap_s1;
			hold_s1 <= hold_reg;
			hold_s2 <= hold_s1;
			{wt_s1, wt_s2, wt_s3} <= {wr_reg.tog, wt_s1, wt_s2};
			{rt_s1, rt_s2, rt_s3} <= {rd_tog_reg, rt_s1, rt_s2};
			frz_s1 <= port_freeze_i;
			frz_s2 <= frz_s1;
		end
	end
	// straps caught once, only after the sync stages hold real levels
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap_reg <= 3'h0;
			strap_done <= 1'b0;
			strap_wait_reg <= 2'h0;
		end else begin
			strap_wait_reg <= {strap_wait_reg[0], 1'b1};
			// capture on the third clock after release
			if (strap_wait_reg[1] && !strap_done) begin
				strap_reg <= strap_s2;
				strap_done <= 1'b1;
			end
		end
	end
	// snapshot follows pins until the link freezes it
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			snap_reg <= 8'hFF;
		end else if (!hold_s2) begin
			snap_reg <= pin_s2;
		end
	end
	// skid stage, data held stable by the link
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend_v <= 1'b0;
			pend_d <= 8'h00;
			bp_reg <= 1'b0;
		end else begin
			if (wr_evt) begin
				pend_v <= 1'b1;
				pend_d <= wr_reg.data;
			end else if (q_ready) begin
				pend_v <= 1'b0;
			end
			bp_reg <= pend_v || !q_ready;
		end
	end

	ioxp_fifo #(
		.W(ioxp_pkg::DATA_W),
		.D(ioxp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_sys_i),
		.rst_i(sys_rst_i),
		.in_valid_i(pend_v),
		.in_ready_o(q_ready),
		.in_data_i(pend_d),
		.out_valid_o(q_valid),
		.out_ready_i(!frz_s2),
		.out_data_o(q_data)
	);

	// ==========================================
	// port latch
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			latch_reg <= ioxp_pkg::PORT_RESET;
		end else if (pop) begin
			latch_reg <= q_data;
		end
	end
	// zero bits pull the pin low, ones leave it weak
	assign port_pin_o = 8'h00;
	assign port_pin_oe_n_o = latch_reg;
	latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!pop |=> $stable(latch_reg)) else $error("latch changed without write");
	latch_load_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		pop |=> latch_reg == $past(q_data)) else $error("latch missed write");

	// ==========================================
	// interrupt: compare pins against reference
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ref_reg <= 8'hFF;
			clr_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			if (rd_evt || pop) begin
				clr_reg <= ioxp_pkg::CLR_CYCLES;
			end else if (clr_reg != 2'h0) begin
				clr_reg <= clr_reg - 2'h1;
			end
			if (clr_reg != 2'h0 || rd_evt || pop) begin
				ref_reg <= pin_s2;
			end
			irq_reg <= (pin_s2 != ref_reg) && clr_reg == 2'h0 && !rd_evt && !pop;
		end
	end
	// open drain, pulled low while active
	assign irq_o = 1'b0;
	assign irq_oe_n_o = !irq_reg;
	irq_edge_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(pin_s2 != ref_reg) && clr_reg == 2'h0 && !rd_evt && !pop |=> !irq_oe_n_o)
		else $error("edge did not raise interrupt");
	irq_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_evt || pop |=> irq_oe_n_o [*3]) else $error("access did not clear interrupt");
endmodule

// *** tb/ioxp_i2c_master.sv ***
// i2c bus master model that drives the expander's serial link
`timescale 1ns/1ns

// ==========================================
// master on the far side of the link
module ioxp_i2c_master #(
	parameter int Q = 624 // quarter scl period, 15.6 periods of the 40 ns system clock
) (
	output logic scl_o,
	output logic sda_low_o,
	input wire logic sda_i
);
	// idle bus: clock parked high, data released to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// one clock pulse; data moves mid-low only, so it never looks like start or stop
	task automatic bit_cycle(input logic v, output logic s);
		#Q sda_low_o = ~v;
		#Q scl_o = 1'b1;
		#Q s = sda_i;
		#Q scl_o = 1'b0;
	endtask
	task automatic start();
		#Q sda_low_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b1;
		#Q scl_o = 1'b0;
	endtask
	// msb first, then the ninth clock reads the acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(b[i], s);
		end
		bit_cycle(1'b1, s);
		ack = ~s;
	endtask
	// line released while the device sends; own answer on the ninth clock
	task automatic recv_byte(input logic give_ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, s);
			b[i] = s;
		end
		bit_cycle(~give_ack, s);
	endtask
	// stop: data rises while the clock is high, bus left idle
	task automatic stop();
		#Q sda_low_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b0;
		#Q;
	endtask
endmodule

// *** tb/ioxp_top_tb.sv ***
// self-checking bench for the io expander, driven by the master model
`timescale 1ns/1ns
module ioxp_top_tb;
	// ==========================================
	// stimulus and resolved wires
	logic clk_sys_i = 1'b0; // 25 MHz system clock
	logic sys_rst_i = 1'b0; // raised by the first reset, so its edge is seen
	logic alt_sel = 1'b0; // routes the link to the alternate variant
	logic [2:0] strap = 3'h5; // address straps
	logic [7:0] ext_pins = 8'hFF; // outside drivers, one means released
	logic port_freeze = 1'b0; // stalls the byte queue
	wire scl; // link clock from the master
	wire sda_m_low; // master pulls data low
	wire sda_oe_n; // device pulls data low
	wire [7:0] port_oe_n; // port latch seen as pull-down enables
	wire irq_oe_n; // interrupt pull-down
	wire sda_oe_n_alt; // alternate variant pulls data low
	wire [7:0] alt_oe_n; // alternate variant port latch
	wire [9:0] drv_low; // levels driven while enabled
	wire sda_line = ~(sda_m_low | ~sda_oe_n | ~sda_oe_n_alt); // pull-up wins when nobody drives
	wire scl_alt = alt_sel ? scl : 1'b1; // idle bus unless selected
	wire sda_alt = alt_sel ? sda_line : 1'b1;
	wire [7:0] pin_line = ext_pins & port_oe_n; // weak pull-up on each pin
	wire irq_line = irq_oe_n; // open drain with pull-up
	int bad_count = 0; // mismatches
	int n_checks = 0; // comparisons made
	int cyc = 0; // cycles since start
	logic ack; // acknowledge seen by the master
	logic [7:0] rd; // byte read back
	logic [6:0] own; // current device address
	logic [7:0] ids [3] = '{ioxp_pkg::ID_MAKER, ioxp_pkg::ID_PART, ioxp_pkg::ID_REV};

	// clock: toggles each half period
	always #20 clk_sys_i = ~clk_sys_i;

	// hang guard: a run far past the expected length fails
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ==========================================
	// instances
	ioxp_i2c_master i_ioxp_i2c_master (.scl_o(scl), .sda_low_o(sda_m_low), .sda_i(sda_line));
	ioxp_top #(.ALT_VARIANT(1'b0)) i_ioxp_top (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.scl_i(scl),
		.sda_i(sda_line),
		.sda_o(drv_low[0]),
		.sda_oe_n_o(sda_oe_n),
		.addr_strap_bit0_i(strap[0]),
		.addr_strap_bit1_i(strap[1]),
		.addr_strap_bit2_i(strap[2]),
		.port_pin_i(pin_line),
		.port_pin_o(drv_low[8:1]),
		.port_pin_oe_n_o(port_oe_n),
		.port_freeze_i(port_freeze),
		.irq_o(drv_low[9]),
		.irq_oe_n_o(irq_oe_n)
	);
	// alternate variant, sees the link only while selected
	ioxp_top #(.ALT_VARIANT(1'b1)) i_ioxp_top_alt (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.scl_i(scl_alt),
		.sda_i(sda_alt),
		.sda_o(),
		.sda_oe_n_o(sda_oe_n_alt),
		.addr_strap_bit0_i(strap[0]),
		.addr_strap_bit1_i(strap[1]),
		.addr_strap_bit2_i(strap[2]),
		.port_pin_i(alt_oe_n),
		.port_pin_o(),
		.port_pin_oe_n_o(alt_oe_n),
		.port_freeze_i(port_freeze),
		.irq_o(),
		.irq_oe_n_o()
	);

	// ==========================================
	// helpers
	task automatic check1(input logic got, input logic exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic waitc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	// straps only settle at reset, so a new strap value needs a reset
	task automatic do_reset(input logic [2:0] s);
		@(negedge clk_sys_i);
		strap = s;
		sys_rst_i = 1'b1;
		waitc(5);
		sys_rst_i = 1'b0;
		waitc(8);
		own = {ioxp_pkg::ADDR_PFX_BASE, s};
	endtask
	task automatic set_pins(input logic [7:0] v);
		@(negedge clk_sys_i);
		ext_pins = v;
		waitc(6);
	endtask
	task automatic addr_phase(input logic [6:0] a, input logic dir, output logic k);
		i_ioxp_i2c_master.start();
		i_ioxp_i2c_master.send_byte({a, dir}, k);
	endtask
	task automatic write_byte(input logic [7:0] d);
		addr_phase(own, 1'b0, ack);
		i_ioxp_i2c_master.send_byte(d, ack);
		i_ioxp_i2c_master.stop();
		waitc(20);
	endtask
	task automatic read_one(output logic [7:0] d);
		addr_phase(own, 1'b1, ack);
		check1(ack, 1'b1, "read address refused");
		i_ioxp_i2c_master.recv_byte(1'b0, d);
		i_ioxp_i2c_master.stop();
		waitc(10);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		check8(port_oe_n, 8'hFF, "port not released after reset");
		check1(irq_line, 1'b1, "interrupt active after reset");
		check8(drv_low[7:0], 8'h00, "open-drain level not low");
		check8({6'h00, drv_low[9:8]}, 8'h00, "open-drain level not low");
	endtask
	// reserved addresses refused, own prefix 0111 taken
	task automatic t_alt();
		@(negedge clk_sys_i);
		alt_sel = 1'b1;
		addr_phase(ioxp_pkg::GEN_CALL_ADDR, 1'b0, ack);
		check1(ack, 1'b0, "general call acked");
		addr_phase(ioxp_pkg::DEV_ID_ADDR, 1'b0, ack);
		check1(ack, 1'b0, "id address taken as own");
		addr_phase({ioxp_pkg::ADDR_PFX_ALT, strap}, 1'b0, ack);
		check1(ack, 1'b1, "alternate address refused");
		i_ioxp_i2c_master.send_byte(8'h5C, ack);
		check1(ack, 1'b1, "alternate data refused");
		i_ioxp_i2c_master.stop();
		waitc(20);
		check8(alt_oe_n, 8'h5C, "alternate port not written");
		@(negedge clk_sys_i);
		alt_sel = 1'b0;
	endtask
	// every strap setting: own address taken, neighbours left alone
	task automatic t_addr();
		for (int s = 0; s < 8; s++) begin
			do_reset(s[2:0]);
			addr_phase({ioxp_pkg::ADDR_PFX_BASE, s[2:0] ^ 3'h7}, 1'b0, ack);
			check1(ack, 1'b0, "foreign strap address acked");
			i_ioxp_i2c_master.send_byte(8'h00, ack);
			addr_phase({ioxp_pkg::ADDR_PFX_ALT, s[2:0]}, 1'b0, ack);
			check1(ack, 1'b0, "other prefix acked");
			addr_phase(own, 1'b0, ack);
			check1(ack, 1'b1, "own address refused");
			i_ioxp_i2c_master.stop();
			waitc(20);
			check8(port_oe_n, 8'hFF, "ignored transfer reached port");
		end
		do_reset(3'h5);
	endtask
	task automatic t_write();
		addr_phase(own, 1'b0, ack);
		i_ioxp_i2c_master.send_byte(8'hA5, ack);
		check1(ack, 1'b1, "data byte refused");
		waitc(10);
		check8(port_oe_n, 8'hA5, "first byte not on port");
		i_ioxp_i2c_master.send_byte(8'h3C, ack);
		waitc(10);
		check8(port_oe_n, 8'h3C, "second byte did not overwrite");
		i_ioxp_i2c_master.stop();
		waitc(600);
		check8(port_oe_n, 8'h3C, "latch lost its value");
	endtask
	// low nibble written low, so pins read outside level and latch together
	task automatic t_read();
		set_pins(8'hA5);
		write_byte(8'hF0);
		read_one(rd);
		check8(rd, 8'hA0, "read byte differs from pins");
		check8(port_oe_n, 8'hF0, "read disturbed latch");
	endtask
	task automatic t_irq();
		waitc(20);
		check1(irq_line, 1'b1, "interrupt without change");
		set_pins(8'h25);
		check1(irq_line, 1'b0, "falling edge missed");
		set_pins(8'hA5);
		check1(irq_line, 1'b1, "held after pins restored");
		set_pins(8'hE5);
		check1(irq_line, 1'b0, "rising edge missed");
		read_one(rd);
		check8(rd, 8'hE0, "read after change");
		check1(irq_line, 1'b1, "read left interrupt set");
		set_pins(8'hC5);
		check1(irq_line, 1'b0, "edge after rearm missed");
		write_byte(8'hF0);
		check1(irq_line, 1'b1, "write left interrupt set");
	endtask
	task automatic t_id();
		addr_phase(ioxp_pkg::DEV_ID_ADDR, 1'b1, ack);
		check1(ack, 1'b1, "id address refused");
		for (int i = 0; i < 3; i++) begin
			i_ioxp_i2c_master.recv_byte(i < 2, rd);
			check8(rd, ids[i], "id byte");
		end
		i_ioxp_i2c_master.stop();
	endtask
	// queue filled while the port side stalls, then drained
	task automatic t_fifo();
		@(negedge clk_sys_i);
		port_freeze = 1'b1;
		addr_phase(own, 1'b0, ack);
		for (int i = 0; i < 32; i++) begin
			i_ioxp_i2c_master.send_byte(8'h80 + i[7:0], ack);
			check1(ack, 1'b1, "queued byte refused");
		end
		i_ioxp_i2c_master.send_byte(8'h55, ack);
		check1(ack, 1'b0, "full queue took a byte");
		i_ioxp_i2c_master.stop();
		waitc(10);
		check8(port_oe_n, 8'hF0, "stalled latch moved");
		port_freeze = 1'b0;
		waitc(200);
		check8(port_oe_n, 8'h9F, "last queued byte not on port");
	endtask

	// main sequence
	initial begin
		do_reset(3'h5);
		t_reset();
		t_addr();
		t_write();
		t_read();
		t_irq();
		t_id();
		t_fifo();
		t_alt();
		give_verdict();
	end
endmodule
